//--- pkg/bos_pkg.sv
// constants for the binary output selector
// Function
// (R1) four terminals, each with own function select
// (R2) chosen function may be inverted per terminal
// (R3) per-terminal delay passes only stable levels
// (R4) code 2: zero or binary input override
// (R5) code 4: high in ready-to-switch-on state
// (R6) code 5: high in wait-operating-enable state
// (R7) code 6: high in any run state
// (R8) code 8 supply present, code 7 auxiliaries
// (R9) codes 9, 10 low-active contactor off
// (R10) code 11 low-active line contactor checkback
// (R11) code 12: ramp-function generator active
// (R12) code 13: counter-clockwise rotation with hysteresis
// (R13) code 14 low-active brake switch-on command
// (R14) codes 16-21 speed below thresholds
// (R15) code 22: speed setpoint reached
// (R16) codes 24-26 low-active alarm outputs
// (R17) code 27 low-active cooling fault, unsuppressed
// (R18) code 29: current setpoint at limit
// (R19) codes 30, 31 field contactor commands
// (R20) code 32 torque change, 33 power hot
// (R21) codes 34, 35 limit value monitors
// (R22) code 3 low-active fault indication
// (R23) fault low in fault state, else high
// (R24) codes above 35 drive zero
// (R25) codes 0 and 1 constant zero, one
package bos_pkg;
   localparam int unsigned NUM_OUT = 4;
   localparam int unsigned SEL_W   = 6;
   localparam int unsigned DLY_W   = 16;
   localparam int unsigned TICK_W  = 24;

   // register byte addresses
   localparam logic [7:0] INVERT_OFS = 8'h00;
   localparam logic [7:0] SELECT_OFS = 8'h04;
   localparam logic [7:0] DELAY1_OFS = 8'h08;
   localparam logic [7:0] DELAY2_OFS = 8'h0c;
   localparam logic [7:0] DELAY3_OFS = 8'h10;
   localparam logic [7:0] DELAY4_OFS = 8'h14;
   localparam logic [7:0] STATUS_OFS = 8'h18;

   // field positions
   localparam int unsigned STATUS_TERM_LSB = 0;
   localparam int unsigned STATUS_RAW_LSB  = 4;

   // reset values
   localparam logic [3:0]       INVERT_RST = 4'h0;
   localparam logic [SEL_W-1:0] SELECT_RST = 6'h00;
   localparam logic [DLY_W-1:0] DELAY_RST  = 16'h0000;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // operating state codes (0 = run)
   localparam logic [3:0] ST_RUN         = 4'h0;
   localparam logic [3:0] ST_WAIT_ENABLE = 4'h1;
   localparam logic [3:0] ST_READY_ON    = 4'h7;
   localparam logic [3:0] ST_FAULT       = 4'hb;

   // selection codes
   localparam logic [SEL_W-1:0] SEL_ZERO     = 6'h00;
   localparam logic [SEL_W-1:0] SEL_ONE      = 6'h01;
   localparam logic [SEL_W-1:0] SEL_OVERRIDE = 6'h02;
   localparam logic [SEL_W-1:0] SEL_FAULT    = 6'h03;
   localparam logic [SEL_W-1:0] SEL_READY_ON = 6'h04;
   localparam logic [SEL_W-1:0] SEL_READY    = 6'h05;
   localparam logic [SEL_W-1:0] SEL_RUN      = 6'h06;
   localparam logic [SEL_W-1:0] SEL_LAST     = 6'h23;

   // delay time base: one millisecond per delay unit
   localparam int unsigned CLOCK_PERIOD_PS = 4000;
   localparam int unsigned DELAY_UNIT_NS   = 1000000;
   localparam int unsigned DELAY_UNIT_CYCLES =
      DELAY_UNIT_NS * 1000 / CLOCK_PERIOD_PS;
endpackage

//--- core/bos_selector.sv
// four selectable, invertible, delay-filtered binary output terminals
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module bos_selector #(
   parameter int unsigned DELAY_UNIT_CYCLES = bos_pkg::DELAY_UNIT_CYCLES
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // axi4-lite write address
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   // axi4-lite write data
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // axi4-lite read
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // drive status, same clock
   input  wire logic [3:0]  op_state,
   input  wire logic        aux_on,
   input  wire logic        supply_present,
   input  wire logic        contactor_ctrl_off,
   input  wire logic        estop_contactor_off,
   input  wire logic        line_contactor_in_input,
   input  wire logic        ramp_active,
   input  wire logic        ccw_rotation,
   input  wire logic        brake_on_cmd,
   input  wire logic        current_above_ix,
   input  wire logic [5:0]  speed_below,
   input  wire logic        speed_set_reached,
   input  wire logic        speed_below_excess,
   input  wire logic        alarm_any,
   input  wire logic        motor_overload_alarm_a,
   input  wire logic        motor_overload_alarm_b,
   input  wire logic        motor_overload_alarm_c,
   input  wire logic        converter_overload_alarm,
   input  wire logic        cooling_fault,
   input  wire logic        field_below_min,
   input  wire logic        current_at_limit,
   input  wire logic [1:0]  field_contactor_cmd,
   input  wire logic        torque_dir_changed,
   input  wire logic        power_section_hot,
   input  wire logic [1:0]  limit_monitor,
   // binary input override, one per terminal
   input  wire logic [3:0]  override_en,
   input  wire logic [3:0]  override_level,
   // terminals
   output logic [3:0]       terminal_out
);
   localparam int unsigned N  = bos_pkg::NUM_OUT;
   localparam int unsigned SW = bos_pkg::SEL_W;
   localparam int unsigned DW = bos_pkg::DLY_W;

   typedef struct packed {
      logic [N-1:0]         inv;
      logic [N-1:0][SW-1:0] sel;
      logic [N-1:0][DW-1:0] dly;
      logic [N-1:0][DW-1:0] cnt;
      logic [N-1:0]         term;
      logic [bos_pkg::TICK_W-1:0] tick_cnt;
      logic                 tick;
      logic                 aw_got;
      logic [7:0]           aw_addr;
      logic                 w_got;
      logic [31:0]          wdata;
      logic [3:0]           wstrb;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
   } bos_state_s;

   bos_state_s st_ff;
   bos_state_s nxt_st;
   logic [N-1:0] func_lvl;
   logic [N-1:0] raw_lvl;
   logic [N-1:0] dly_done;

   // internal function level for one selection code
   function automatic logic func_level(input logic [SW-1:0] code,
                                       input logic ovr_en,
                                       input logic ovr_lvl);
      logic v;
      v = 1'b0;
      case (code)
         // (R25) constant levels
         6'h00: v = 1'b0;
         6'h01: v = 1'b1;
         // (R4) override by binary input
         6'h02: v = ovr_en & ovr_lvl;
         // (R22) (R23) fault low active
         6'h03: v = (op_state != bos_pkg::ST_FAULT);
         // (R5) ready to switch on
         6'h04: v = (op_state == bos_pkg::ST_READY_ON);
         // (R6) waiting for enable
         6'h05: v = (op_state == bos_pkg::ST_WAIT_ENABLE);
         // (R7) any run state
         6'h06: v = (op_state == bos_pkg::ST_RUN);
         // (R8) auxiliaries and supply
         6'h07: v = aux_on;
         6'h08: v = supply_present;
         // (R9) contactor off, low active
         6'h09: v = ~contactor_ctrl_off;
         6'h0a: v = ~estop_contactor_off;
         // (R10) checkback low active
         6'h0b: v = ~line_contactor_in_input;
         // (R11) ramp generator
         6'h0c: v = ramp_active;
         // (R12) rotation, hysteresis upstream
         6'h0d: v = ccw_rotation;
         // (R13) brake command low active
         6'h0e: v = ~brake_on_cmd;
         6'h0f: v = current_above_ix;
         // (R14) speed thresholds
         6'h10: v = speed_below[0];
         6'h11: v = speed_below[1];
         6'h12: v = speed_below[2];
         6'h13: v = speed_below[3];
         6'h14: v = speed_below[4];
         6'h15: v = speed_below[5];
         // (R15) setpoint reached
         6'h16: v = speed_set_reached;
         6'h17: v = speed_below_excess;
         // (R16) alarms low active
         6'h18: v = ~alarm_any;
         6'h19: v = ~(motor_overload_alarm_a | motor_overload_alarm_b
                      | motor_overload_alarm_c);
         6'h1a: v = ~converter_overload_alarm;
         // (R17) cooling fault regardless of suppression
         6'h1b: v = ~cooling_fault;
         6'h1c: v = ~field_below_min;
         // (R18) current limit
         6'h1d: v = current_at_limit;
         // (R19) field contactors
         6'h1e: v = field_contactor_cmd[0];
         6'h1f: v = field_contactor_cmd[1];
         // (R20) torque change, power hot
         6'h20: v = torque_dir_changed;
         6'h21: v = power_section_hot;
         // (R21) limit monitors
         6'h22: v = limit_monitor[0];
         6'h23: v = limit_monitor[1];
         // (R24) reserved codes
         default: v = 1'b0;
      endcase
      return v;
   endfunction

   // (R1) one selector per terminal
   for (genvar g = 0; g < N; g++)
   begin : g_out
      logic lvl;
      // always_comb, so status inputs read inside the function wake it
      always_comb
      begin
         lvl = func_level(st_ff.sel[g], override_en[g], override_level[g]);
      end
      assign func_lvl[g] = lvl;
      // (R2) inversion before filter
      assign raw_lvl[g]  = func_lvl[g] ^ st_ff.inv[g];
      assign dly_done[g] = (st_ff.cnt[g] >= st_ff.dly[g]);
   end

   always_comb
   begin
      logic [31:0] rd;
      logic        wr_ok;
      logic        rd_ok;
      rd     = 32'h0000_0000;
      wr_ok  = 1'b1;
      rd_ok  = 1'b1;
      nxt_st = st_ff;

      // millisecond time base
      nxt_st.tick = 1'b0;
      if (st_ff.tick_cnt >= DELAY_UNIT_CYCLES[bos_pkg::TICK_W-1:0] - 1'b1)
      begin
         nxt_st.tick_cnt = '0;
         nxt_st.tick     = 1'b1;
      end
      else
      begin
         nxt_st.tick_cnt = st_ff.tick_cnt + 1'b1;
      end

      // (R3) stability filter
      for (int i = 0; i < N; i++)
      begin
         if (raw_lvl[i] == st_ff.term[i])
         begin
            nxt_st.cnt[i] = '0;
         end
         else if (dly_done[i])
         begin
            nxt_st.term[i] = raw_lvl[i];
            nxt_st.cnt[i]  = '0;
         end
         else if (st_ff.tick)
         begin
            nxt_st.cnt[i] = st_ff.cnt[i] + 1'b1;
         end
      end

      // write channel capture
      if (s_axi_awvalid && s_axi_awready)
      begin
         nxt_st.aw_got  = 1'b1;
         nxt_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
      end
      if (st_ff.aw_got && st_ff.w_got)
      begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got  = 1'b0;
         nxt_st.bvalid = 1'b1;
         case (st_ff.aw_addr & 8'hfc)
            bos_pkg::INVERT_OFS:
               if (st_ff.wstrb[0])
               begin
                  nxt_st.inv = st_ff.wdata[3:0];
               end
            bos_pkg::SELECT_OFS:
               for (int i = 0; i < N; i++)
               begin
                  if (st_ff.wstrb[i])
                  begin
                     nxt_st.sel[i] = st_ff.wdata[8*i +: SW];
                  end
               end
            bos_pkg::DELAY1_OFS, bos_pkg::DELAY2_OFS,
            bos_pkg::DELAY3_OFS, bos_pkg::DELAY4_OFS:
               for (int b = 0; b < 2; b++)
               begin
                  if (st_ff.wstrb[b])
                  begin
                     nxt_st.dly[st_ff.aw_addr[3:2] - 2'h2][8*b +: 8] =
                        st_ff.wdata[8*b +: 8];
                  end
               end
            bos_pkg::STATUS_OFS: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
         endcase
         nxt_st.bresp = wr_ok ? bos_pkg::RESP_OKAY : bos_pkg::RESP_SLVERR;
      end
      else if (st_ff.bvalid && s_axi_bready)
      begin
         nxt_st.bvalid = 1'b0;
      end

      // read channel
      if (s_axi_arvalid && s_axi_arready)
      begin
         case (s_axi_araddr & 8'hfc)
            bos_pkg::INVERT_OFS: rd[3:0] = st_ff.inv;
            bos_pkg::SELECT_OFS:
               for (int i = 0; i < N; i++)
               begin
                  rd[8*i +: SW] = st_ff.sel[i];
               end
            bos_pkg::DELAY1_OFS: rd[DW-1:0] = st_ff.dly[0];
            bos_pkg::DELAY2_OFS: rd[DW-1:0] = st_ff.dly[1];
            bos_pkg::DELAY3_OFS: rd[DW-1:0] = st_ff.dly[2];
            bos_pkg::DELAY4_OFS: rd[DW-1:0] = st_ff.dly[3];
            bos_pkg::STATUS_OFS:
            begin
               rd[bos_pkg::STATUS_TERM_LSB +: N] = st_ff.term;
               rd[bos_pkg::STATUS_RAW_LSB +: N]  = raw_lvl;
            end
            default: rd_ok = 1'b0;
         endcase
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata  = rd;
         nxt_st.rresp  = rd_ok ? bos_pkg::RESP_OKAY : bos_pkg::RESP_SLVERR;
      end
      else if (st_ff.rvalid && s_axi_rready)
      begin
         nxt_st.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         st_ff     <= '0;
         st_ff.inv <= bos_pkg::INVERT_RST;
         for (int i = 0; i < N; i++)
         begin
            st_ff.sel[i] <= bos_pkg::SELECT_RST;
            st_ff.dly[i] <= bos_pkg::DELAY_RST;
         end
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign s_axi_awready = ~st_ff.aw_got & ~st_ff.bvalid;
   assign s_axi_wready  = ~st_ff.w_got & ~st_ff.bvalid;
   assign s_axi_bvalid  = st_ff.bvalid;
   assign s_axi_bresp   = st_ff.bresp;
   assign s_axi_arready = ~st_ff.rvalid;
   assign s_axi_rvalid  = st_ff.rvalid;
   assign s_axi_rdata   = st_ff.rdata;
   assign s_axi_rresp   = st_ff.rresp;
   assign terminal_out  = st_ff.term;

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   term_change_a: assert property ( // (R3)
      $changed(st_ff.term[0]) |-> $past(raw_lvl[0]) == st_ff.term[0]
         && $past(dly_done[0]))
      else $error("terminal changed before stable time");
   term_follow_a: assert property ( // (R3)
      st_ff.dly[1] == '0 && $stable(st_ff.dly[1]) && $stable(raw_lvl[1])
         |=> st_ff.term[1] == $past(raw_lvl[1]))
      else $error("zero delay terminal did not follow");
   const_one_a: assert property ( // (R25)
      st_ff.sel[0] == bos_pkg::SEL_ONE |-> raw_lvl[0] == ~st_ff.inv[0])
      else $error("code one level wrong");
   invert_zero_a: assert property ( // (R2)
      st_ff.sel[2] == bos_pkg::SEL_ZERO |-> raw_lvl[2] == st_ff.inv[2])
      else $error("inversion not applied");
   override_sel_a: assert property ( // (R4)
      st_ff.sel[0] == bos_pkg::SEL_OVERRIDE |->
         func_lvl[0] == (override_en[0] & override_level[0]))
      else $error("override code level wrong");
   fault_low_a: assert property ( // (R22)
      st_ff.sel[1] == bos_pkg::SEL_FAULT |->
         func_lvl[1] == (op_state != bos_pkg::ST_FAULT))
      else $error("fault indication wrong");
   ready_on_a: assert property ( // (R5)
      st_ff.sel[0] == bos_pkg::SEL_READY_ON |->
         func_lvl[0] == (op_state == bos_pkg::ST_READY_ON))
      else $error("ready to switch on wrong");
   ready_wait_a: assert property ( // (R6)
      st_ff.sel[3] == bos_pkg::SEL_READY |->
         func_lvl[3] == (op_state == bos_pkg::ST_WAIT_ENABLE))
      else $error("ready state wrong");
   run_state_a: assert property ( // (R7)
      st_ff.sel[2] == bos_pkg::SEL_RUN |->
         func_lvl[2] == (op_state == bos_pkg::ST_RUN))
      else $error("run indication wrong");
   reserved_zero_a: assert property ( // (R24)
      st_ff.sel[3] > bos_pkg::SEL_LAST |-> func_lvl[3] == 1'b0)
      else $error("reserved code not zero");

   write_cov_c: cover property (st_ff.bvalid && s_axi_bready);
   read_cov_c: cover property (st_ff.rvalid && s_axi_rready);
   filter_cov_c: cover property (
      st_ff.dly[0] != '0 && $changed(st_ff.term[0]));
   glitch_cov_c: cover property (
      st_ff.cnt[0] != '0 ##1 st_ff.cnt[0] == '0 && $stable(st_ff.term[0]));
endmodule

//--- verification/bos_relay_model.sv
// relay coils behind the terminals, counting level changes
`timescale 1ns/1ps
module bos_relay_model (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // terminal levels from the device
   input  wire logic [3:0] coil,
   // coil transitions seen since reset
   output logic [7:0]      edges
);
   logic [3:0] last_ff;

   always_ff @(posedge clock)
   begin
      last_ff <= coil;
      if (reset)
         edges <= 8'h00;
      else
         edges <= edges + 8'($countones(coil ^ last_ff));
   end
endmodule

//--- verification/binary_output_selector_test.sv
// self-checking bench for the binary output selector
`timescale 1ns/1ps
module binary_output_selector_test;
   logic        clock, reset, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr, edges;
   logic [31:0] wdata, rdata, seed, d;
   logic [1:0]  bresp, rresp, r;
   logic [34:0] st;
   logic [3:0]  ov_en, ov_lv, term, inv, e;
   int          miscompares, compares, i, k, t, ops [4];
   int          sel [4];
   logic [31:0] msk [6];

   bos_selector #(.DELAY_UNIT_CYCLES(4)) u_bos_selector (
      .clock(clock), .reset(reset),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .op_state(st[3:0]), .aux_on(st[4]), .supply_present(st[5]),
      .contactor_ctrl_off(st[6]), .estop_contactor_off(st[7]),
      .line_contactor_in_input(st[8]), .ramp_active(st[9]),
      .ccw_rotation(st[10]), .brake_on_cmd(st[11]),
      .current_above_ix(st[12]), .speed_below(st[18:13]),
      .speed_set_reached(st[19]), .speed_below_excess(st[20]),
      .alarm_any(st[21]), .motor_overload_alarm_a(st[22]),
      .motor_overload_alarm_b(st[23]), .motor_overload_alarm_c(st[24]),
      .converter_overload_alarm(st[25]), .cooling_fault(st[26]),
      .field_below_min(st[27]), .current_at_limit(st[28]),
      .field_contactor_cmd(st[30:29]), .torque_dir_changed(st[31]),
      .power_section_hot(st[32]), .limit_monitor(st[34:33]),
      .override_en(ov_en), .override_level(ov_lv), .terminal_out(term)
   );

   bos_relay_model u_bos_relay_model (
      .clock(clock), .reset(reset), .coil(term), .edges(edges)
   );

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // model of one terminal before filtering
   function automatic logic xp(int c, int t);
      logic v;
      if (c > 35)
         v = 1'b0;
      else if (c == 25)
         v = ~|st[24:22];
      else if (c >= 26)
         v = st[c-1];
      else if (c >= 7)
         v = st[c-3];
      else
         case (c)
            0: v = 1'b0;
            1: v = 1'b1;
            2: v = ov_en[t] & ov_lv[t];
            3: v = st[3:0] != 4'hb;
            4: v = st[3:0] == 4'h7;
            5: v = st[3:0] == 4'h1;
            default: v = st[3:0] == 4'h0;
         endcase
      if (c inside {9, 10, 11, 14, 24, 26, 27, 28})
         v = ~v;
      return v ^ inv[t];
   endfunction

   task automatic end_of_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] x, logic [31:0] s);
      compares++;
      if (s !== x)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
         miscompares++;
      end
   endtask

   task automatic hung();
      $display("CHECK FAILED bus wait expected answer seen none");
      miscompares++;
      end_of_test();
   endtask

   task automatic axw(logic [7:0] a, logic [31:0] v, output logic [1:0] rs);
      int n;
      @(posedge clock);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clock);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      if (n == 50)
         hung();
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic axr(logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
      int n;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clock);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      if (n == 50)
         hung();
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   initial
   begin
      reset = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      st = '0;
      ov_en = '0;
      ov_lv = '0;
      inv = '0;
      seed = 85190;
      miscompares = 0;
      compares = 0;
      ops = '{0, 1, 7, 11};
      msk = '{32'h0000_000f, 32'h3f3f_3f3f, 32'h0000_ffff,
              32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff};
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      // reset values, read masks, unmapped places
      for (i = 0; i < 9; i++)
      begin
         axr(8'(i * 4), d, r);
         chk("reset read", 0, d);
         chk("read resp", (i < 7) ? 0 : 2, 32'(r));
      end
      for (i = 0; i < 6; i++)
      begin
         axw(8'(i * 4), 32'hffff_ffff, r);
         axr(8'(i * 4), d, r);
         chk("read back", msk[i], d);
         axw(8'(i * 4), 32'h0000_0000, r);
      end
      axw(bos_pkg::STATUS_OFS, 32'h0000_00ff, r);
      chk("status write", 0, 32'(r));
      axw(8'h40, 32'h0000_0001, r);
      chk("unmapped write", 2, 32'(r));
      $display("test registers done");
      // every code on every terminal, random status
      for (k = 0; k < 128; k++)
      begin
         for (t = 0; t < 4; t++)
            sel[t] = (k + t * 17) % 64;
         d = rnd();
         inv = d[3:0];
         axw(bos_pkg::SELECT_OFS, {2'b00, 6'(sel[3]), 2'b00, 6'(sel[2]),
             2'b00, 6'(sel[1]), 2'b00, 6'(sel[0])}, r);
         axw(bos_pkg::INVERT_OFS, 32'(inv), r);
         d = rnd();
         st <= {31'(rnd()), (d[2:0] < 3'h4) ? 4'(ops[d[1:0]]) : d[7:4]};
         ov_en <= d[11:8];
         ov_lv <= d[15:12];
         repeat (3) @(posedge clock);
         #1;
         for (t = 0; t < 4; t++)
            e[t] = xp(sel[t], t);
         chk("terminals", 32'(e), 32'(term));
         axr(bos_pkg::STATUS_OFS, d, r);
         chk("status", 32'({e, e}), d);
      end // covers also
      $display("test code sweep done");
      // per-terminal delay filter
      axw(bos_pkg::SELECT_OFS, 32'h0202_0202, r);
      axw(bos_pkg::INVERT_OFS, 32'h0000_0000, r);
      for (t = 0; t < 4; t++)
         axw(bos_pkg::DELAY1_OFS + 8'(t * 4), 32'(t + 2), r);
      ov_en <= 4'hf;
      ov_lv <= 4'h0;
      repeat (30) @(posedge clock);
      k = int'(edges);
      ov_lv <= 4'hf;
      repeat (3) @(posedge clock);
      ov_lv <= 4'h0;
      repeat (30) @(posedge clock);
      chk("short pulse", 32'(k), 32'(edges));
      ov_lv <= 4'hf;
      repeat (3) @(posedge clock);
      #1;
      chk("early level", 0, 32'(term));
      repeat (11) @(posedge clock);
      #1;
      chk("own delays", 32'h1, 32'(term & 4'b1001));
      repeat (16) @(posedge clock);
      #1;
      chk("long level", 32'hf, 32'(term));
      chk("relay edges", 32'(8'(k + 4)), 32'(edges));
      $display("test delay filter done");
      end_of_test();
   end
endmodule
